// [pcp_mcu_model.sv]
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Far-side model: the microcontroller address strobe and a free-running common clock.
module pcp_mcu_model (
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic reset_n,
   // Request for one strobe pulse.
   input wire logic strobe_req,
   // Pins toward the fourth port.
   output logic clk_pin,
   output logic strobe_pin
);
   // Divider for the common clock, eight system cycles a period.
   logic [2:0] div_reg;
   // Remaining cycles of the strobe pulse.
   logic [1:0] pulse_reg;

   ////////////////////////////////////////////////////////////////////////////////
   // The common clock runs free, since it is an independent oscillator.
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         div_reg <= 3'h0;
      end else begin
         div_reg <= div_reg + 3'h1;
      end
   end
   assign clk_pin = div_reg[2];

   // A strobe pulse lasts two cycles, which is long enough to pass the pin sync.
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         pulse_reg <= 2'h0;
      end else if (strobe_req) begin
         pulse_reg <= 2'h2;
      end else if (pulse_reg != 2'h0) begin
         pulse_reg <= pulse_reg - 2'h1;
      end
   end
   // Idle strobe level is low; the pulse is high.
   assign strobe_pin = (pulse_reg != 2'h0);
endmodule

// [pcp_pkg.sv]
package pcp_pkg;

   // Port widths.
   localparam int PORT_C_W = 8;
   localparam int PORT_D_W = 3;

   // Fourth-port dedicated pin positions.
   localparam int PD_STROBE_BIT = 0;
   localparam int PD_CLOCK_BIT = 1;
   localparam int PD_CSEL_BIT = 2;

   // Third-port special pin positions.
   localparam int PC_BATT_IN_BIT = 2;
   localparam int PC_BATT_FLAG_BIT = 4;
   localparam int PC_DBE_BIT = 7;

   // First power register field positions.
   localparam int PM0_APD_BIT = 1;
   localparam int PM0_TURBO_OFF_BIT = 3;
   localparam int PM0_CLK_BLOCK_BIT = 4;

   // Second power register field positions.
   localparam int PM2_CNTL0_BIT = 2;
   localparam int PM2_CNTL1_BIT = 3;
   localparam int PM2_CNTL2_BIT = 4;
   localparam int PM2_ALE_BIT = 5;
   localparam int PM2_DBE_BIT = 6;

   // Power register reset values.
   localparam logic [7:0] PM0_RESET = 8'h00;
   localparam logic [7:0] PM2_RESET = 8'h00;

   // Inactivity counter.
   localparam int APD_CNT_W = 4;
   localparam logic [APD_CNT_W-1:0] APD_LIMIT = 4'hf;
   localparam logic [APD_CNT_W-1:0] APD_ZERO = 4'h0;

   // Third-port pin function.
   typedef enum logic [1:0] {
      PCP_FN_MCU_IO,
      PCP_FN_LOGIC_IN,
      PCP_FN_ADDR_IN
   } pcp_fn_t;

   // Power mode of the device.
   typedef enum logic {
      PCP_RUN,
      PCP_DOWN
   } pcp_mode_t;

   // Port pin group: input, output and output enable.
   typedef struct packed {
      logic [PORT_C_W-1:0] in;
      logic [PORT_C_W-1:0] out;
      logic [PORT_C_W-1:0] oe;
   } pcp_pc_pins_t;

   // Signals that feed the logic arrays.
   typedef struct packed {
      logic strobe;
      logic clock;
      logic dbe;
      logic [2:0] cntl;
      logic [PORT_C_W-1:0] pc_in;
      logic [PORT_D_W-1:0] pd_in;
   } pcp_logic_in_t;

endpackage

// [pcp_port_power.sv]
`timescale 1ns/1ps
module pcp_port_power (
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic reset_n,
   // Power register write port from the MCU side.
   input wire logic pm0_wr,
   input wire logic pm2_wr,
   input wire logic [7:0] pm_wdata,
   // Strobe polarity that counts as inactive.
   input wire logic strobe_idle_level,
   // Third-port configuration.
   input wire logic [7:0] pc_prog_sel,
   input wire logic [7:0] pc_logic_sel,
   input wire logic [7:0] pc_addr_sel,
   input wire logic [7:0] pc_dir,
   input wire logic [7:0] pc_open_drain,
   input wire logic [7:0] pc_data_out,
   input wire logic pc_batt_in_en,
   input wire logic pc_batt_flag_en,
   input wire logic pc_dbe_en,
   input wire logic batt_low_main,
   // Third-port pins.
   input wire logic [7:0] pc_pin_in,
   output logic [7:0] pc_pin_out,
   output logic [7:0] pc_pin_oe,
   // Fourth-port configuration.
   input wire logic [2:0] pd_dir,
   input wire logic [2:0] pd_data_out,
   input wire logic [2:0] pd_logic_out_sel,
   input wire logic [2:0] pd_logic_out,
   input wire logic strobe_en,
   input wire logic clock_en,
   input wire logic csel_en,
   // Fourth-port pins.
   input wire logic [2:0] pd_pin_in,
   output logic [2:0] pd_pin_out,
   output logic [2:0] pd_pin_oe,
   // Other array control inputs.
   input wire logic [2:0] cntl_in,
   // MCU address and data toward the memories.
   input wire logic [15:0] mcu_addr,
   input wire logic [7:0] mcu_data,
   // Gated results and status.
   output logic [15:0] mem_addr,
   output logic [7:0] mem_data,
   output logic [7:0] pc_mcu_in,
   output logic [7:0] pc_addr_in,
   output logic [2:0] pd_mcu_in,
   output pcp_pkg::pcp_logic_in_t logic_in,
   output logic flash_sel,
   output logic sram_sel,
   output logic io_window_sel,
   output logic mem_standby,
   output logic logic_standby,
   output logic power_down,
   output logic [7:0] pm0_q,
   output logic [7:0] pm2_q
);

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers.

   // Two stages for every pin; only the second stage is read.
   logic [7:0] pc_s1_reg;
   logic [7:0] pc_s2_reg;
   logic [2:0] pd_s1_reg;
   logic [2:0] pd_s2_reg;
   logic [2:0] ct_s1_reg;
   logic [2:0] ct_s2_reg;
   logic bl_s1_reg;
   logic bl_s2_reg;

   // Sample all external pins into the clock domain.
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         pc_s1_reg <= 8'h00;
         pc_s2_reg <= 8'h00;
         pd_s1_reg <= 3'h0;
         pd_s2_reg <= 3'h0;
         ct_s1_reg <= 3'h0;
         ct_s2_reg <= 3'h0;
         bl_s1_reg <= 1'b0;
         bl_s2_reg <= 1'b0;
      end else begin
         pc_s1_reg <= pc_pin_in;
         pc_s2_reg <= pc_s1_reg;
         pd_s1_reg <= pd_pin_in;
         pd_s2_reg <= pd_s1_reg;
         ct_s1_reg <= cntl_in;
         ct_s2_reg <= ct_s1_reg;
         bl_s1_reg <= batt_low_main;
         bl_s2_reg <= bl_s1_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Power registers.

   // Registers are written at run time; turbo is on since its bit resets to 0.
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         pm0_q <= pcp_pkg::PM0_RESET;
         pm2_q <= pcp_pkg::PM2_RESET;
      end else begin
         if (pm0_wr) begin
            pm0_q <= pm_wdata;
         end
         if (pm2_wr) begin
            pm2_q <= pm_wdata;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Dedicated fourth-port functions and strobe activity.

   // Dedicated inputs, seen only when configured.
   logic strobe_lvl;
   logic clock_lvl;
   logic csel_high;
   logic strobe_prev_reg;
   logic clock_prev_reg;
   logic strobe_edge;
   logic clock_tick;
   logic apd_on;

   assign strobe_lvl = strobe_en & pd_s2_reg[pcp_pkg::PD_STROBE_BIT];
   assign clock_lvl = clock_en & pd_s2_reg[pcp_pkg::PD_CLOCK_BIT];
   assign csel_high = csel_en & pd_s2_reg[pcp_pkg::PD_CSEL_BIT];
   assign apd_on = pm0_q[pcp_pkg::PM0_APD_BIT];

   // Previous levels for edge detection on synchronised signals.
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         strobe_prev_reg <= 1'b0;
         clock_prev_reg <= 1'b0;
      end else begin
         strobe_prev_reg <= strobe_lvl;
         clock_prev_reg <= clock_lvl;
      end
   end

   // Any strobe change is activity; a clock period is its rising edge.
   assign strobe_edge = strobe_lvl ^ strobe_prev_reg;
   assign clock_tick = clock_lvl & ~clock_prev_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Automatic power-down counter and mode.

   logic [pcp_pkg::APD_CNT_W-1:0] apd_cnt_reg;
   pcp_pkg::pcp_mode_t mode_reg;
   logic strobe_idle;

   // The strobe must sit at its idle level to count.
   assign strobe_idle = (strobe_lvl == strobe_idle_level) & ~strobe_edge;

   // Counter runs on common-clock periods, which the block filter never hides.
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         apd_cnt_reg <= pcp_pkg::APD_ZERO;
      end else if (!apd_on || !strobe_idle) begin
         apd_cnt_reg <= pcp_pkg::APD_ZERO;
      end else if (clock_tick && apd_cnt_reg != pcp_pkg::APD_LIMIT) begin
         apd_cnt_reg <= apd_cnt_reg + 4'h1;
      end
   end

   // Mode: down after fifteen idle clocks; wake on strobe or select low.
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         mode_reg <= pcp_pkg::PCP_RUN;
      end else begin
         case (mode_reg)
            pcp_pkg::PCP_RUN: begin
               if (apd_on && strobe_idle && clock_tick &&
                   apd_cnt_reg == pcp_pkg::APD_LIMIT - 4'h1) begin
                  mode_reg <= pcp_pkg::PCP_DOWN;
               end
            end
            default: begin
               if (strobe_edge || !apd_on || (csel_en && !csel_high)) begin
                  mode_reg <= pcp_pkg::PCP_RUN;
               end
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Gating toward memories and logic arrays.

   logic down;
   logic mem_off;
   logic [2:0] cntl_gated;
   logic [7:0] pc_logic_in;
   pcp_pkg::pcp_logic_in_t li_next;
   logic [$bits(pcp_pkg::pcp_logic_in_t)-1:0] li_prev_reg;
   logic li_change;
   logic [15:0] addr_prev_reg;
   logic [7:0] data_prev_reg;

   assign down = (mode_reg == pcp_pkg::PCP_DOWN);
   // Chip deselect idles only the memories, never the arrays.
   assign mem_off = down | csel_high;

   // Programming pins are withheld from the array inputs too.
   assign pc_logic_in = pc_s2_reg & pc_logic_sel & ~pc_prog_sel;
   assign cntl_gated[0] = ct_s2_reg[0] & ~pm2_q[pcp_pkg::PM2_CNTL0_BIT];
   assign cntl_gated[1] = ct_s2_reg[1] & ~pm2_q[pcp_pkg::PM2_CNTL1_BIT];
   assign cntl_gated[2] = ct_s2_reg[2] & ~pm2_q[pcp_pkg::PM2_CNTL2_BIT];

   // Array inputs: power-down does not block non-bus inputs.
   always_comb begin
      li_next.strobe = strobe_lvl & ~pm2_q[pcp_pkg::PM2_ALE_BIT];
      li_next.clock = clock_lvl & ~pm0_q[pcp_pkg::PM0_CLK_BLOCK_BIT];
      li_next.dbe = pc_dbe_en & ~pc_prog_sel[pcp_pkg::PC_DBE_BIT] &
                    pc_s2_reg[pcp_pkg::PC_DBE_BIT] & ~pm2_q[pcp_pkg::PM2_DBE_BIT];
      li_next.cntl = cntl_gated;
      li_next.pc_in = pc_logic_in;
      // Dedicated strobe and clock reach the arrays only through their gated fields.
      li_next.pd_in = pd_s2_reg & ~{1'b0, clock_en, strobe_en};
   end

   // Registered outputs and change tracking.
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         logic_in <= '0;
         li_prev_reg <= '0;
         mem_addr <= 16'h0000;
         mem_data <= 8'h00;
         addr_prev_reg <= 16'h0000;
         data_prev_reg <= 8'h00;
      end else begin
         logic_in <= li_next;
         li_prev_reg <= li_next;
         addr_prev_reg <= mcu_addr;
         data_prev_reg <= mcu_data;
         if (!down) begin
            mem_addr <= mcu_addr;
            mem_data <= mcu_data;
         end
      end
   end

   assign li_change = (li_next != li_prev_reg);

   // Standby flags: memories wake only on an ungated, selected change.
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         mem_standby <= 1'b1;
         logic_standby <= 1'b0;
         flash_sel <= 1'b0;
         sram_sel <= 1'b0;
         io_window_sel <= 1'b0;
         power_down <= 1'b0;
      end else begin
         mem_standby <= mem_off | ((mcu_addr == addr_prev_reg) &&
                        (mcu_data == data_prev_reg));
         // With turbo on the arrays never idle; off, they idle when quiet.
         logic_standby <= pm0_q[pcp_pkg::PM0_TURBO_OFF_BIT] & ~li_change;
         flash_sel <= ~mem_off;
         sram_sel <= ~mem_off;
         io_window_sel <= ~mem_off;
         power_down <= down;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Port pin drivers and MCU read paths.

   logic [7:0] pc_drive;
   logic [7:0] pc_out_val;
   logic [7:0] pc_special;

   // Battery pins and DBE leave MCU I/O; no address-output select exists.
   always_comb begin
      pc_special = 8'h00;
      pc_special[pcp_pkg::PC_BATT_IN_BIT] = pc_batt_in_en;
      pc_special[pcp_pkg::PC_BATT_FLAG_BIT] = pc_batt_flag_en;
      pc_special[pcp_pkg::PC_DBE_BIT] = pc_dbe_en;
      pc_drive = pc_dir & ~pc_prog_sel & ~pc_special;
      pc_out_val = pc_data_out;
      pc_out_val[pcp_pkg::PC_BATT_FLAG_BIT] = pc_batt_flag_en ? bl_s2_reg :
                                              pc_data_out[pcp_pkg::PC_BATT_FLAG_BIT];
      // The flag pin stays ordinary I/O unless the flag function claims it.
      if (pc_batt_flag_en) begin
         pc_drive[pcp_pkg::PC_BATT_FLAG_BIT] = ~pc_prog_sel[pcp_pkg::PC_BATT_FLAG_BIT];
      end
   end

   // Open-drain pins drive only low; push-pull drive whenever enabled.
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         pc_pin_out <= 8'h00;
         pc_pin_oe <= 8'h00;
         pc_mcu_in <= 8'h00;
         pc_addr_in <= 8'h00;
      end else begin
         pc_pin_out <= pc_out_val & ~pc_open_drain;
         pc_pin_oe <= pc_drive & ~(pc_open_drain & pc_out_val);
         pc_mcu_in <= pc_s2_reg & ~pc_prog_sel;
         pc_addr_in <= pc_s2_reg & pc_addr_sel & ~pc_prog_sel;
      end
   end

   logic [2:0] pd_ded;
   logic [2:0] pd_out_val;

   // Three pins only; dedicated inputs never drive.
   always_comb begin
      pd_ded = {csel_en, clock_en, strobe_en};
      pd_out_val = (pd_logic_out_sel & pd_logic_out) |
                   (~pd_logic_out_sel & pd_data_out);
   end

   // Fourth-port drivers and MCU read path.
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         pd_pin_out <= 3'h0;
         pd_pin_oe <= 3'h0;
         pd_mcu_in <= 3'h0;
      end else begin
         pd_pin_out <= pd_out_val;
         pd_pin_oe <= (pd_dir | pd_logic_out_sel) & ~pd_ded;
         pd_mcu_in <= pd_s2_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Assertions.

   sequence s_idle_clock;
      clock_tick && strobe_idle && apd_on;
   endsequence

   property p_down_selects;
      @(posedge sys_clk) disable iff (!reset_n)
      down |=> !flash_sel && !sram_sel && !io_window_sel;
   endproperty
   a_down_selects: assert property (p_down_selects) else $error("selected in down");

   property p_csel_off;
      @(posedge sys_clk) disable iff (!reset_n)
      csel_high |=> !flash_sel && mem_standby;
   endproperty
   a_csel_off: assert property (p_csel_off) else $error("csel did not idle");

   property p_no_apd;
      @(posedge sys_clk) disable iff (!reset_n)
      !apd_on |=> apd_cnt_reg == pcp_pkg::APD_ZERO;
   endproperty
   a_no_apd: assert property (p_no_apd) else $error("counter ran disabled");

   property p_strobe_clear;
      @(posedge sys_clk) disable iff (!reset_n)
      strobe_edge |=> apd_cnt_reg == pcp_pkg::APD_ZERO && !down;
   endproperty
   a_strobe_clear: assert property (p_strobe_clear) else $error("strobe no clear");

   property p_enter_down;
      @(posedge sys_clk) disable iff (!reset_n)
      (s_idle_clock and apd_cnt_reg == pcp_pkg::APD_LIMIT - 4'h1) |=> down;
   endproperty
   a_enter_down: assert property (p_enter_down) else $error("no power-down");

   property p_bus_hold;
      @(posedge sys_clk) disable iff (!reset_n)
      down |=> $stable(mem_addr) && $stable(mem_data);
   endproperty
   a_bus_hold: assert property (p_bus_hold) else $error("bus passed in down");

   property p_turbo_on;
      @(posedge sys_clk) disable iff (!reset_n)
      !pm0_q[pcp_pkg::PM0_TURBO_OFF_BIT] |=> !logic_standby;
   endproperty
   a_turbo_on: assert property (p_turbo_on) else $error("standby in turbo");

   property p_prog_withheld;
      @(posedge sys_clk) disable iff (!reset_n)
      1'b1 |=> (pc_pin_oe & $past(pc_prog_sel)) == 8'h00;
   endproperty
   a_prog_withheld: assert property (p_prog_withheld) else $error("prog pin driven");

   property p_ded_nodrive;
      @(posedge sys_clk) disable iff (!reset_n)
      strobe_en |=> !pd_pin_oe[pcp_pkg::PD_STROBE_BIT];
   endproperty
   a_ded_nodrive: assert property (p_ded_nodrive) else $error("strobe pin driven");

endmodule

// [pcp_port_power_tb.sv]
`timescale 1ns/1ps
// Compares one value against its expectation and counts the outcome.
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin fail_count++; \
   $display("unexpected %s exp %0h got %0h", nm, e, g); end end
////////////////////////////////////////////////////////////////////////////////
module pcp_port_power_tb;
   // Stimulus held by the bench.
   logic sys_clk = 1'b0, reset_n = 1'b0, pm0_wr = 1'b0, pm2_wr = 1'b0;
   logic [7:0] pm_wdata = 8'h00, pc_prog_sel = 8'h00, pc_logic_sel = 8'h00;
   logic [7:0] pc_addr_sel = 8'h00, pc_dir = 8'h00, pc_open_drain = 8'h00;
   logic [7:0] pc_data_out = 8'h00, pc_pin_in = 8'h00, mcu_data = 8'h00;
   logic strobe_idle_level = 1'b0, pc_batt_in_en = 1'b0, pc_batt_flag_en = 1'b0;
   logic pc_dbe_en = 1'b0, batt_low_main = 1'b0, strobe_en = 1'b0, clock_en = 1'b0;
   logic csel_en = 1'b0, csel_pin = 1'b1, strobe_req = 1'b0;
   logic [2:0] pd_dir = 3'h0, pd_data_out = 3'h0, pd_logic_out_sel = 3'h0;
   logic [2:0] pd_logic_out = 3'h0, cntl_in = 3'h0;
   logic [15:0] mcu_addr = 16'h0000;
   // Observed outputs.
   logic [7:0] pc_pin_out, pc_pin_oe, mem_data, pc_mcu_in, pc_addr_in, pm0_q, pm2_q;
   logic [2:0] pd_pin_out, pd_pin_oe, pd_mcu_in;
   logic [15:0] mem_addr;
   pcp_pkg::pcp_logic_in_t logic_in;
   logic flash_sel, sram_sel, io_window_sel, mem_standby, logic_standby, power_down;
   logic clk_pin, strobe_pin, seen;
   wire logic [2:0] pd_pin_in;
   int fail_count = 0;
   int total_checks = 0;

   // Fourth-port pins: chip select from the bench, clock and strobe from the model.
   assign pd_pin_in = {csel_pin, clk_pin, strobe_pin};
   always #5 sys_clk = ~sys_clk;

   pcp_port_power u_dut (.sys_clk, .reset_n, .pm0_wr, .pm2_wr, .pm_wdata,
      .strobe_idle_level, .pc_prog_sel, .pc_logic_sel, .pc_addr_sel, .pc_dir,
      .pc_open_drain, .pc_data_out, .pc_batt_in_en, .pc_batt_flag_en, .pc_dbe_en,
      .batt_low_main, .pc_pin_in, .pc_pin_out, .pc_pin_oe, .pd_dir, .pd_data_out,
      .pd_logic_out_sel, .pd_logic_out, .strobe_en, .clock_en, .csel_en, .pd_pin_in,
      .pd_pin_out, .pd_pin_oe, .cntl_in, .mcu_addr, .mcu_data, .mem_addr, .mem_data,
      .pc_mcu_in, .pc_addr_in, .pd_mcu_in, .logic_in, .flash_sel, .sram_sel,
      .io_window_sel, .mem_standby, .logic_standby, .power_down, .pm0_q, .pm2_q);
   pcp_mcu_model u_mcu (.sys_clk, .reset_n, .strobe_req, .clk_pin, .strobe_pin);

   ////////////////////////////////////////////////////////////////////////////////
   // Waits n edges, then lets their updates settle before sampling.
   task automatic wt(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask

   // Writes one power register: sel 0 is the first, sel 1 the second.
   task automatic wr_pm(input logic sel, input logic [7:0] d);
      @(posedge sys_clk);
      pm0_wr <= !sel;
      pm2_wr <= sel;
      pm_wdata <= d;
      @(posedge sys_clk);
      pm0_wr <= 1'b0;
      pm2_wr <= 1'b0;
      #1;
   endtask

   // Asks the model for one strobe pulse.
   task automatic pulse();
      @(posedge sys_clk);
      strobe_req <= 1'b1;
      @(posedge sys_clk);
      strobe_req <= 1'b0;
   endtask

   // Bounded wait for the power-down level; the caller compares afterwards.
   task automatic wait_pd(input logic v, input int lim);
      for (int i = 0; i < lim && power_down !== v; i++) wt(1);
   endtask

   // Prints the counts and the verdict, then ends the run.
   task automatic stop_test();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // The tests take a few hundred cycles; this cuts a hang short.
   initial begin
      #100us;
      fail_count++;
      stop_test();
   end

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (8) @(posedge sys_clk);
      reset_n <= 1'b1;
      wt(2);
      // Reset state: registers clear, turbo on, no power-down.
      `CHK("pm0_q", 8'h00, pm0_q)
      `CHK("pm2_q", 8'h00, pm2_q)
      `CHK("power_down", 1'b0, power_down)
      `CHK("logic_standby", 1'b0, logic_standby)
      wr_pm(1'b1, 8'h7c);
      `CHK("pm2_q", 8'h7c, pm2_q)
      // Blocking bits gate the control inputs from the arrays: bit 0 alone, then all three.
      cntl_in <= 3'h7;
      wr_pm(1'b1, 8'h04);
      wt(4);
      `CHK("cntl", 3'h6, logic_in.cntl)
      wr_pm(1'b1, 8'h1c);
      wt(4);
      `CHK("cntl", 3'h0, logic_in.cntl)
      wr_pm(1'b1, 8'h00);
      wt(4);
      `CHK("cntl", 3'h7, logic_in.cntl)
      // Turbo off with the clock blocked and inputs still: arrays idle.
      clock_en <= 1'b1;
      strobe_en <= 1'b1;
      wr_pm(1'b0, 8'h18);
      wt(8);
      `CHK("logic_standby", 1'b1, logic_standby)
      `CHK("clock_blk", 1'b0, logic_in.clock)
      wr_pm(1'b0, 8'h00);
      wt(2);
      `CHK("logic_standby", 1'b0, logic_standby)
      // Addresses pass while running and the memory idles once they settle.
      mcu_addr <= 16'h1234;
      mcu_data <= 8'h5a;
      seen = 1'b0;
      repeat (4) begin
         wt(1);
         if (mem_standby === 1'b0) seen = 1'b1;
      end
      `CHK("wake", 1'b1, seen)
      wt(4);
      `CHK("mem_standby", 1'b1, mem_standby)
      `CHK("mem_addr", 16'h1234, mem_addr)
      `CHK("mem_data", 8'h5a, mem_data)
      // Enable power-down: fifteen idle clock ticks, not thirteen.
      wr_pm(1'b0, 8'h02);
      `CHK("pm0_q", 8'h02, pm0_q)
      wt(104);
      `CHK("power_down", 1'b0, power_down)
      wait_pd(1'b1, 40);
      `CHK("power_down", 1'b1, power_down)
      // In power-down the bus is frozen and memories deselected.
      @(posedge sys_clk);
      mcu_addr <= 16'habcd;
      mcu_data <= 8'ha5;
      wt(4);
      `CHK("mem_addr", 16'h1234, mem_addr)
      `CHK("mem_data", 8'h5a, mem_data)
      `CHK("io_window_sel", 1'b0, io_window_sel)
      `CHK("flash_sel", 1'b0, flash_sel)
      `CHK("sram_sel", 1'b0, sram_sel)
      `CHK("mem_standby", 1'b1, mem_standby)
      // A strobe pulse wakes the device and restarts the count.
      pulse();
      wait_pd(1'b0, 8);
      `CHK("power_down", 1'b0, power_down)
      wt(104);
      `CHK("power_down", 1'b0, power_down)
      wait_pd(1'b1, 40);
      `CHK("power_down", 1'b1, power_down)
      // The chip select returning low also wakes the device.
      csel_en <= 1'b1;
      csel_pin <= 1'b0;
      wait_pd(1'b0, 8);
      `CHK("power_down", 1'b0, power_down)
      // Deselect: memories off and idle, arrays still fed.
      csel_pin <= 1'b1;
      pc_logic_sel <= 8'hff;
      pc_pin_in <= 8'ha5;
      mcu_addr <= 16'h5555;
      wt(5);
      `CHK("flash_sel", 1'b0, flash_sel)
      `CHK("sram_sel", 1'b0, sram_sel)
      `CHK("io_window_sel", 1'b0, io_window_sel)
      `CHK("mem_standby", 1'b1, mem_standby)
      `CHK("pc_in", 8'ha5, logic_in.pc_in)
      wr_pm(1'b0, 8'h00);
      csel_en <= 1'b0;
      // Third port: programming pins withheld, open drain drives low only.
      pc_dir <= 8'hff;
      pc_data_out <= 8'hf0;
      pc_prog_sel <= 8'h03;
      pc_open_drain <= 8'hc0;
      pc_addr_sel <= 8'hff;
      pc_pin_in <= 8'hff;
      wt(5);
      `CHK("pc_oe", 8'h3c, pc_pin_oe)
      `CHK("pc_out", 8'h30, pc_pin_out & 8'h3c)
      `CHK("pc_addr_in", 8'hfc, pc_addr_in)
      `CHK("pc_mcu_in", 8'hfc, pc_mcu_in)
      pc_data_out <= 8'h00;
      wt(5);
      `CHK("pc_oe", 8'hfc, pc_pin_oe)
      // Battery flag follows the synced supply comparison.
      pc_batt_flag_en <= 1'b1;
      batt_low_main <= 1'b1;
      wt(6);
      `CHK("flag_out", 1'b1, pc_pin_out[4])
      `CHK("flag_oe", 1'b1, pc_pin_oe[4])
      // Fourth port: dedicated pins never drive; the rest carry array outputs.
      pd_dir <= 3'h7;
      pd_logic_out_sel <= 3'h7;
      pd_logic_out <= 3'h5;
      wt(5);
      `CHK("pd_oe", 3'h4, pd_pin_oe)
      `CHK("pd_out2", 1'b1, pd_pin_out[2])
      `CHK("pd_mcu_in2", 1'b1, pd_mcu_in[2])
      stop_test();
   end
endmodule
